// [hcc_pkg.sv]
/*
 * Shared constants and types for the haptic calibration and top
 * configuration register slice: register indices, byte addresses,
 * field positions, reset values and the packed carriers for the APB
 * request and for the configuration handed to the drive engines.
 * Assumes a 32-bit APB with byte addressing, one register per word.
 */
package hcc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int HCC_ADDR_W = 8;
    localparam logic [7:0] HCC_IDX_SCALE_LOW = 8'h10;
    localparam logic [7:0] HCC_IDX_IMP_HIGH = 8'h11;
    localparam logic [7:0] HCC_IDX_IMP_LOW = 8'h12;
    localparam logic [7:0] HCC_IDX_TOP_CONFIGURATION_ONE = 8'h13;
    // Printed offsets are not word multiples, so they are word indices
    localparam logic [HCC_ADDR_W-1:0] HCC_ADDR_SCALE_LOW =
        HCC_ADDR_W'(HCC_IDX_SCALE_LOW * 4);
    localparam logic [HCC_ADDR_W-1:0] HCC_ADDR_IMP_HIGH =
        HCC_ADDR_W'(HCC_IDX_IMP_HIGH * 4);
    localparam logic [HCC_ADDR_W-1:0] HCC_ADDR_IMP_LOW =
        HCC_ADDR_W'(HCC_IDX_IMP_LOW * 4);
    localparam logic [HCC_ADDR_W-1:0] HCC_ADDR_TOP_CONFIGURATION_ONE =
        HCC_ADDR_W'(HCC_IDX_TOP_CONFIGURATION_ONE * 4);

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] HCC_RST_SCALE_LOW = 8'h0D;
    localparam logic [7:0] HCC_RST_IMP_HIGH = 8'h00;
    localparam logic [1:0] HCC_RST_IMP_LOW = 2'h0;
    localparam logic [7:0] HCC_RST_TOP_CONFIGURATION_ONE = 8'h1E;

    // ------------------------------------------------------------
    // Top configuration field positions
    // ------------------------------------------------------------
    localparam int HCC_BIT_EMBEDDED = 7;
    localparam int HCC_BIT_ERM = 5;
    localparam int HCC_BIT_BEMF = 4;
    localparam int HCC_BIT_FOLLOW = 3;
    localparam int HCC_BIT_ACCEL = 2;
    localparam int HCC_BIT_RSTOP = 1;
    localparam int HCC_BIT_AMP = 0;
    // Bit 6 is undefined and never stored
    localparam logic [7:0] HCC_CFG1_MASK = 8'hBF;
    localparam int HCC_IMP_LOW_W = 2;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [HCC_ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } hcc_apb_req_type;

    typedef struct packed {
        logic fault_auto_clear;
        logic actuator_erm;
        logic back_emf_loop_enable;
        logic resonance_follow_enable;
        logic accel_enable;
        logic rapid_stop_enable;
        logic amplitude_loop_enable;
    } hcc_cfg_type;

endpackage

// [hcc_regs_top.sv]
/*
 * Register slice: low byte of the drive scale factor, measured
 * impedance readback and the top configuration byte, on an APB slave.
 * Assumes the impedance engine and the drive engines share mclk.
 */
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
module hcc_regs_top (
    input wire logic mclk,
    input wire logic rst,
    input wire hcc_pkg::hcc_apb_req_type apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic imp_update,
    input wire logic [7:0] imp_high_in,
    input wire logic [1:0] imp_low_in,
    output logic [7:0] drive_scale_low_byte,
    output hcc_pkg::hcc_cfg_type cfg
);
    import hcc_pkg::*;

    // Engine view of the reset configuration, so that the enables do
    // not read all-zero for the first cycles after reset is released.
    localparam hcc_cfg_type HCC_CFG_RST = '{
        fault_auto_clear: HCC_RST_TOP_CONFIGURATION_ONE[HCC_BIT_EMBEDDED],
        actuator_erm: HCC_RST_TOP_CONFIGURATION_ONE[HCC_BIT_ERM],
        back_emf_loop_enable: HCC_RST_TOP_CONFIGURATION_ONE[HCC_BIT_BEMF],
        resonance_follow_enable: HCC_RST_TOP_CONFIGURATION_ONE[HCC_BIT_FOLLOW]
            & ~HCC_RST_TOP_CONFIGURATION_ONE[HCC_BIT_ERM],
        accel_enable: HCC_RST_TOP_CONFIGURATION_ONE[HCC_BIT_ACCEL],
        rapid_stop_enable: HCC_RST_TOP_CONFIGURATION_ONE[HCC_BIT_RSTOP],
        amplitude_loop_enable: HCC_RST_TOP_CONFIGURATION_ONE[HCC_BIT_AMP]
    };

    logic [7:0] scale_low_q;
    logic [7:0] imp_high_q;
    logic [1:0] imp_low_q;
    logic [7:0] cfg1_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    hcc_cfg_type cfg_q;
    hcc_cfg_type cfg_d;
    logic access;
    logic commit;
    logic wr_en;
    logic hit;
    logic [31:0] rdata_d;

    // ------------------------------------------------------------
    // APB handshake
    // ------------------------------------------------------------
    // One wait state: pready rises in the second access cycle, which
    // keeps read data a registered output.
    assign access = apb_req.psel & apb_req.penable;
    assign commit = access & pready_q;
    assign wr_en = commit & apb_req.pwrite & apb_req.pstrb[0];

    always_comb begin
        hit = 1'b1;
        rdata_d = 32'h0000_0000;
        case (apb_req.paddr)
            HCC_ADDR_SCALE_LOW: rdata_d[7:0] = scale_low_q;
            HCC_ADDR_IMP_HIGH: rdata_d[7:0] = imp_high_q;
            HCC_ADDR_IMP_LOW: rdata_d[1:0] = imp_low_q;
            HCC_ADDR_TOP_CONFIGURATION_ONE: rdata_d[7:0] = cfg1_q & HCC_CFG1_MASK;
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= access & ~pready_q;
            pslverr_q <= access & ~pready_q & ~hit;
            if (access & ~pready_q & ~apb_req.pwrite) begin
                prdata_q <= rdata_d;
            end else if (commit) begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    // Only byte lane 0 carries data; other lanes are ignored.
    always_ff @(posedge mclk) begin
        if (rst) begin
            scale_low_q <= HCC_RST_SCALE_LOW;
        end else if (wr_en && apb_req.paddr == HCC_ADDR_SCALE_LOW) begin
            scale_low_q <= apb_req.pwdata[7:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg1_q <= HCC_RST_TOP_CONFIGURATION_ONE;
        end else if (wr_en && apb_req.paddr == HCC_ADDR_TOP_CONFIGURATION_ONE) begin
            cfg1_q <= apb_req.pwdata[7:0] & HCC_CFG1_MASK;
        end
    end

    // ------------------------------------------------------------
    // Measured impedance, written only by the measurement engine
    // ------------------------------------------------------------
    // Bus writes to these addresses complete without error but do
    // nothing; only the engine's update pulse loads them.
    always_ff @(posedge mclk) begin
        if (rst) begin
            imp_high_q <= HCC_RST_IMP_HIGH;
            imp_low_q <= HCC_RST_IMP_LOW;
        end else if (imp_update) begin
            imp_high_q <= imp_high_in;
            imp_low_q <= imp_low_in;
        end
    end

    // ------------------------------------------------------------
    // Configuration to the drive engines
    // ------------------------------------------------------------
    always_comb begin
        cfg_d.fault_auto_clear = cfg1_q[HCC_BIT_EMBEDDED];
        cfg_d.actuator_erm = cfg1_q[HCC_BIT_ERM];
        cfg_d.back_emf_loop_enable = cfg1_q[HCC_BIT_BEMF];
        // Tracking has no meaning for a rotating-mass actuator
        cfg_d.resonance_follow_enable =
            cfg1_q[HCC_BIT_FOLLOW] & ~cfg1_q[HCC_BIT_ERM];
        cfg_d.accel_enable = cfg1_q[HCC_BIT_ACCEL];
        cfg_d.rapid_stop_enable = cfg1_q[HCC_BIT_RSTOP];
        cfg_d.amplitude_loop_enable = cfg1_q[HCC_BIT_AMP];
    end

    // Registered so every output leaves a flop; costs one cycle of lag
    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg_q <= HCC_CFG_RST;
            drive_scale_low_byte <= HCC_RST_SCALE_LOW;
        end else begin
            cfg_q <= cfg_d;
            drive_scale_low_byte <= scale_low_q;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign cfg = cfg_q;

endmodule // hcc_regs_top

// [hcc_regs_props.sv]
/* Concurrent checks on the ports of hcc_regs_top.
   Assumes one clock, mclk, and synchronous active-high rst. */
`timescale 1ns/100ps
module hcc_regs_props (
    input wire logic mclk,
    input wire logic rst,
    input wire hcc_pkg::hcc_apb_req_type apb_req,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] drive_scale_low_byte,
    input wire hcc_pkg::hcc_cfg_type cfg
);
    import hcc_pkg::*;
    logic [7:0] w1_q;
    logic [7:0] w2_q;
    logic wr;
    // -----------------------------------------
    // Write data delayed to line up with outputs
    // -----------------------------------------
    always_ff @(posedge mclk) begin
        w1_q <= apb_req.pwdata[7:0];
        w2_q <= w1_q;
    end
    assign wr = pready & apb_req.pwrite & apb_req.pstrb[0] & ~pslverr;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    AST_RDY: assert property ($rose(apb_req.penable) |=> pready)
        else $error("no answer after one wait state");
    AST_ONE: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    AST_RST_SCALE: assert property (
        $fell(rst) |-> drive_scale_low_byte == 8'h0D)
        else $error("scale low byte reset value wrong");
    AST_RST_CFG: assert property (
        $fell(rst) |-> cfg == 7'h1E) else $error("config reset wrong");
    AST_SCALE_WR: assert property (
        wr && apb_req.paddr == HCC_ADDR_SCALE_LOW |->
        ##2 drive_scale_low_byte == w2_q) else $error("scale not written");
    AST_CFG_WR: assert property (
        wr && apb_req.paddr == HCC_ADDR_TOP_CONFIGURATION_ONE |-> ##2 cfg ==
        {w2_q[7], w2_q[5:4], w2_q[3] & ~w2_q[5], w2_q[2:0]})
        else $error("config outputs do not follow write");
    AST_ERM_GATE: assert property (
        cfg.actuator_erm |-> !cfg.resonance_follow_enable)
        else $error("tracking enabled for rotating mass");
    AST_PAD: assert property (
        pready && !apb_req.pwrite && apb_req.paddr == HCC_ADDR_TOP_CONFIGURATION_ONE
        |-> prdata[31:8] == '0 && !prdata[6])
        else $error("unused config bits not zero");
endmodule // hcc_regs_props
bind hcc_regs_top hcc_regs_props u_hcc_regs_props (.mclk, .rst, .apb_req,
    .prdata, .pready, .pslverr, .drive_scale_low_byte, .cfg);

// [tb.sv]
/* Self-checking bench for hcc_regs_top over APB.
   Assumes the checker file is compiled with the design. */
`timescale 1ns/100ps
module tb;
    import hcc_pkg::*;
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] e;
        logic err;
    } hcc_row_type;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    hcc_apb_req_type req = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic imp_update = 1'h0;
    logic [7:0] imp_h = '0;
    logic [1:0] imp_l = '0;
    logic [7:0] scale;
    hcc_cfg_type cfg;
    logic [31:0] rd;
    logic er;
    int fails = 0;
    int samples_checked = 0;
    hcc_row_type rows[12] = '{'{0, 8'h40, 0, 8'h0D, 0},
        '{0, 8'h44, 0, 0, 0}, '{0, 8'h48, 0, 0, 0},
        '{0, 8'h4C, 0, 8'h1E, 0}, '{1, 8'h40, 8'hA5, 0, 0},
        '{0, 8'h40, 0, 8'hA5, 0}, '{1, 8'h4C, 8'hFF, 0, 0},
        '{0, 8'h4C, 0, 8'hBF, 0}, '{1, 8'h44, 8'h77, 0, 0},
        '{0, 8'h44, 0, 0, 0}, '{1, 8'h50, 8'h11, 0, 1},
        '{0, 8'h50, 0, 0, 1}};
    always #50 mclk = ~mclk;
    hcc_regs_top u_hcc_regs_top (.mclk, .rst, .apb_req(req), .prdata,
        .pready, .pslverr, .imp_update, .imp_high_in(imp_h),
        .imp_low_in(imp_l), .drive_scale_low_byte(scale), .cfg);
    // -----------------------------------------
    // Bus cycle, compare and verdict
    // -----------------------------------------
    task apb(input logic w, input logic [7:0] a, d, input logic [3:0] s);
        int n;
        n = 0;
        req <= '{1'h1, 1'h0, w, a, {24'h0, d}, s};
        @(posedge mclk) req.penable <= 1'h1;
        // Values read at the edge are those that the edge samples
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (pready !== 1'h1) fails++;
        req <= '0;
        @(posedge mclk);
    endtask
    task chk(input logic [31:0] g, e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task report_and_stop;
        if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'h0;
        @(negedge mclk);
        chk(scale, 8'h0D);
        chk(cfg, 7'h1E);
        @(posedge mclk);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d, 4'hF);
            chk(er, rows[i].err);
            if (!rows[i].w && !rows[i].err) chk(rd, rows[i].e);
        end
        apb(1'h1, 8'h40, 8'h5A, 4'hE);
        chk(scale, 8'hA5);
        imp_h <= 8'h58;
        imp_l <= 2'h3;
        imp_update <= 1'h1;
        @(posedge mclk) imp_update <= 1'h0;
        apb(1'h0, 8'h44, '0, 4'hF);
        chk(rd, 8'h58);
        apb(1'h1, 8'h48, '0, 4'hF);
        apb(1'h0, 8'h48, '0, 4'hF);
        chk(rd, 2'h3);
        apb(1'h1, 8'h4C, 8'h99, 4'hF);
        @(negedge mclk) chk(cfg, 7'h59);
        @(posedge mclk);
        apb(1'h1, 8'h4C, 8'h2E, 4'hF);
        @(negedge mclk) chk(cfg, 7'h26);
        @(posedge mclk);
        apb(1'h0, 8'h4C, '0, 4'hF);
        chk(rd, 8'h2E);
        rst <= 1'h1;
        repeat (3) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        apb(1'h0, 8'h4C, '0, 4'hF);
        chk(rd, 8'h1E);
        report_and_stop;
    end
    initial begin
        repeat (2000) @(posedge mclk);
        fails++;
        report_and_stop;
    end
endmodule // tb
